// [design/cmfr_config_bank.sv]
// Purpose: Manufacturer configuration and monitor registers with their controls
// Assumes: Command port carries whole byte, word and block transfers in one beat
// Notes:   Pin inputs pass two flip-flops before use
`timescale 1ns/1ps
// Contract
// - Remote trigger when sense reaches threshold
// - Kickstart pretrigger 20 us plus 450 ns/unit
// - Fast input-off at threshold plus offset
// - Power-ok polarity: 0 low, 1 high
// - Bit 7 enables fast overcurrent
// - Bits 12:8 set required over-level samples
// - Bits 6:0 set overcurrent trip level
// - Four 2-bit delay unit fields
// - Delay equals count times unit
// - Read-only monitor: on 31:16, off 15:0
// - Prebias needs input slew within limits
// - Prebias needs output slew within limits
// - Filter select 0 out, 1 current, 2 feed-forward
module cmfr_config_bank #(
	parameter int unsigned MS_CYCLES = cmfr_pkg::MS_CYC
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        arst_n,
	input  wire logic        clkEn,
	// Command port
	input  wire logic        cmdValid,
	input  wire logic        cmdWrite,
	input  wire logic [7:0]  cmdCode,
	input  wire logic [3:0]  cmdLen,
	input  wire logic [63:0] cmdWrData,
	output logic             rspValid,
	output logic [63:0]      rspData,
	output logic             rspError,
	// Pins
	input  wire logic [7:0]  remoteSenseInput,
	input  wire logic [7:0]  vinLevel,
	input  wire logic        vinFallingFast,
	input  wire logic        powerGoodRaw,
	// Converter logic, same clock
	input  wire logic [7:0]  inputOffThreshold,
	input  wire logic [6:0]  currentSample,
	input  wire logic        currentStrobe,
	input  wire logic        kickArm,
	input  wire logic [3:0]  faultStart,
	input  wire logic [31:0] faultCount,
	input  wire logic [15:0] scaleOnCode,
	input  wire logic [15:0] scaleOffCode,
	input  wire logic [15:0] vinSlew,
	input  wire logic [15:0] voutSlew,
	// Controls out
	output logic             remoteTrigger,
	output logic             fastInputOff,
	output logic             powerOkOutput,
	output logic             ocpTrip,
	output logic             kickStart,
	output logic [12:0]      preTrigCycles,
	output logic [3:0]       faultDelayDone,
	output logic             prebiasStartOk,
	output logic [2:0]       filterPath
);
	import cmfr_pkg::*;

	// Reset release
	logic [1:0]  rstPipe_q;
	logic        rst_n;

	// Registers
	logic [7:0]  rcThresh_q;
	logic [7:0]  ksPretrig_q;
	logic [7:0]  fastOffOfs_q;
	logic [7:0]  pgPol_q;
	logic [15:0] fastOcp_q;
	logic [7:0]  unitCfg_q;
	logic [63:0] slewLim_q;
	logic [7:0]  filterSel_q;

	// Pin synchronisers
	logic [17:0] pinMeta_q;
	logic [17:0] pinSync_q;
	logic [7:0]  senseSync;
	logic [7:0]  vinSync;
	logic        fallSync;
	logic        goodSync;

	// Command decode
	logic        lenOk;
	logic        known;
	logic        readOnly;
	logic        wrEn;
	logic [63:0] rdMux;

	// Kickstart timer
	logic [12:0] ksCnt_q;
	logic        ksRun_q;

	cmfr_ocp_if ocpBus ();

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstPipe_q <= 2'b00;
		end else begin
			rstPipe_q <= {rstPipe_q[0], 1'b1};
		end
	end
	assign rst_n = rstPipe_q[1];

	// Only the second stage is read
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta_q <= 18'h00000;
			pinSync_q <= 18'h00000;
		end else if (clkEn) begin
			pinMeta_q <= {remoteSenseInput, vinLevel, vinFallingFast, powerGoodRaw};
			pinSync_q <= pinMeta_q;
		end
	end
	assign senseSync = pinSync_q[17:10];
	assign vinSync   = pinSync_q[9:2];
	assign fallSync  = pinSync_q[1];
	assign goodSync  = pinSync_q[0];

	// Command decode
	always_comb begin
		known    = 1'b1;
		readOnly = 1'b0;
		lenOk    = cmdLen == LEN_BYTE;
		rdMux    = 64'h0;
		unique case (cmdCode)
			CMD_RC_THRESH:  rdMux = {56'h0, rcThresh_q};
			CMD_KS_PRETRIG: rdMux = {56'h0, ksPretrig_q};
			CMD_FAST_OFF:   rdMux = {56'h0, fastOffOfs_q};
			CMD_PG_POL:     rdMux = {56'h0, pgPol_q};
			CMD_FAST_OCP: begin
				lenOk = cmdLen == LEN_WORD;
				rdMux = {48'h0, fastOcp_q & OCP_USED_MASK};
			end
			CMD_UNIT_CFG:   rdMux = {56'h0, unitCfg_q};
			CMD_SCALE_MON: begin
				lenOk    = cmdLen == LEN_MON;
				readOnly = 1'b1;
				rdMux    = {32'h0, scaleOnCode, scaleOffCode};
			end
			CMD_SLEW_LIM: begin
				lenOk = cmdLen == LEN_SLEW;
				rdMux = slewLim_q;
			end
			CMD_FILTER_SEL: rdMux = {56'h0, filterSel_q};
			default: begin
				known = 1'b0;
				lenOk = 1'b0;
			end
		endcase
	end

	// Malformed or read-only writes change nothing
	assign wrEn = cmdValid && cmdWrite && known && lenOk && !readOnly;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rcThresh_q   <= RST_BYTE;
			ksPretrig_q  <= RST_BYTE;
			fastOffOfs_q <= RST_BYTE;
			pgPol_q      <= RST_BYTE;
			fastOcp_q    <= RST_OCP;
			unitCfg_q    <= RST_BYTE;
			slewLim_q    <= RST_SLEW;
			filterSel_q  <= RST_BYTE;
		end else if (clkEn && wrEn) begin
			unique case (cmdCode)
				CMD_RC_THRESH:  rcThresh_q   <= cmdWrData[7:0];
				CMD_KS_PRETRIG: ksPretrig_q  <= cmdWrData[7:0];
				CMD_FAST_OFF:   fastOffOfs_q <= cmdWrData[7:0];
				CMD_PG_POL:     pgPol_q      <= cmdWrData[7:0];
				CMD_FAST_OCP:   fastOcp_q    <= cmdWrData[15:0] & OCP_USED_MASK;
				CMD_UNIT_CFG:   unitCfg_q    <= cmdWrData[7:0];
				CMD_SLEW_LIM:   slewLim_q    <= cmdWrData;
				CMD_FILTER_SEL: filterSel_q  <= cmdWrData[7:0];
				default:        filterSel_q  <= filterSel_q;
			endcase
		end
	end

	// Every taken command answers one cycle later
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rspValid <= 1'b0;
			rspData  <= 64'h0;
			rspError <= 1'b0;
		end else if (clkEn) begin
			rspValid <= cmdValid;
			rspError <= cmdValid && !(known && lenOk && !(cmdWrite && readOnly));
			rspData  <= (cmdValid && !cmdWrite && known && lenOk) ? rdMux : 64'h0;
		end
	end

	// Level controls
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			remoteTrigger  <= 1'b0;
			fastInputOff   <= 1'b0;
			powerOkOutput  <= 1'b0;
			prebiasStartOk <= 1'b0;
			filterPath     <= 3'b000;
		end else if (clkEn) begin
			remoteTrigger <= senseSync >= rcThresh_q;
			// Widened sum so a high offset cannot wrap below the threshold
			fastInputOff  <= fallSync &&
				({1'b0, vinSync} < {1'b0, inputOffThreshold} + {1'b0, fastOffOfs_q});
			powerOkOutput <= pgPol_q[0] ? goodSync : !goodSync;
			prebiasStartOk <=
				($signed(vinSlew) <= $signed(slewLim_q[SLEW_VIN_POS +: 16])) &&
				($signed(vinSlew) >= $signed(slewLim_q[SLEW_VIN_NEG +: 16])) &&
				($signed(voutSlew) <= $signed(slewLim_q[SLEW_VOUT_POS +: 16])) &&
				($signed(voutSlew) >= $signed(slewLim_q[SLEW_VOUT_NEG +: 16]));
			filterPath <= {filterSel_q == FILT_FFWD, filterSel_q == FILT_IOUT,
				filterSel_q == FILT_VOUT};
		end
	end

	// Kickstart lead time and its countdown
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			preTrigCycles <= 13'h0000;
			ksCnt_q       <= 13'h0000;
			ksRun_q       <= 1'b0;
			kickStart     <= 1'b0;
		end else if (clkEn) begin
			preTrigCycles <= 13'(KS_BASE_CYC) + 13'(KS_STEP_CYC) * {5'h00, ksPretrig_q};
			kickStart     <= ksRun_q && ksCnt_q == 13'h0001;
			if (kickArm) begin
				ksCnt_q <= preTrigCycles;
				ksRun_q <= 1'b1;
			end else if (ksRun_q) begin
				ksCnt_q <= ksCnt_q - 13'h0001;
				ksRun_q <= ksCnt_q != 13'h0001;
			end
		end
	end

	// Fast overcurrent
	assign ocpBus.enable        = fastOcp_q[OCP_EN_BIT];
	assign ocpBus.sampleCount   = fastOcp_q[OCP_CNT_HI:OCP_CNT_LO];
	assign ocpBus.tripLevel     = fastOcp_q[OCP_LVL_HI:0];
	assign ocpBus.sampleStrobe  = currentStrobe;
	assign ocpBus.currentSample = currentSample;
	assign ocpTrip              = ocpBus.trip;

	cmfr_ocp_filter u_ocp (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.clkEn   (clkEn),
		.ocp     (ocpBus.filt)
	);

	// Class 3 output voltage, 2 input voltage, 1 output current, 0 temperature
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_delay
			cmfr_delay_timer #(
				.MS_CYCLES (MS_CYCLES)
			) u_timer (
				.sys_clk (sys_clk),
				.rst_n   (rst_n),
				.clkEn   (clkEn),
				.start   (faultStart[gi]),
				.count   (faultCount[gi*8 +: 8]),
				.unitSel (cmfr_unit_t'(unitCfg_q[gi*2 +: 2])),
				.done    (faultDelayDone[gi])
			);
		end
	endgenerate
endmodule

// [design/cmfr_pkg.sv]
// Purpose: Shared constants and types of the converter configuration bank
// Assumes: 40 MHz system clock
// Notes:   Command codes double as register addresses on the command port
package cmfr_pkg;

	// Command codes
	localparam logic [7:0] CMD_RC_THRESH  = 8'hc6;
	localparam logic [7:0] CMD_KS_PRETRIG = 8'hc7;
	localparam logic [7:0] CMD_FAST_OFF   = 8'hc8;
	localparam logic [7:0] CMD_PG_POL     = 8'hd0;
	localparam logic [7:0] CMD_FAST_OCP   = 8'hd1;
	localparam logic [7:0] CMD_UNIT_CFG   = 8'hd2;
	localparam logic [7:0] CMD_SCALE_MON  = 8'hd3;
	localparam logic [7:0] CMD_SLEW_LIM   = 8'hd4;
	localparam logic [7:0] CMD_FILTER_SEL = 8'hd5;

	// Transfer lengths in bytes
	localparam logic [3:0] LEN_BYTE  = 4'h1;
	localparam logic [3:0] LEN_WORD  = 4'h2;
	localparam logic [3:0] LEN_MON   = 4'h4;
	localparam logic [3:0] LEN_SLEW  = 4'h8;

	// Reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_OCP  = 16'h0000;
	localparam logic [63:0] RST_SLEW = 64'h0000_0000_0000_0000;

	// Field positions
	localparam int OCP_EN_BIT  = 7;
	localparam int OCP_CNT_LO  = 8;
	localparam int OCP_CNT_HI  = 12;
	localparam int OCP_LVL_HI  = 6;
	localparam logic [15:0] OCP_USED_MASK = 16'h1fff;
	localparam int SLEW_VIN_POS = 48;
	localparam int SLEW_VIN_NEG = 32;
	localparam int SLEW_VOUT_POS = 16;
	localparam int SLEW_VOUT_NEG = 0;

	// Timing
	localparam int CLK_PERIOD_PS = 25000;
	localparam int KS_BASE_NS    = 20000;
	localparam int KS_STEP_NS    = 450;
	localparam int KS_BASE_CYC   = (KS_BASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int KS_STEP_CYC   = (KS_STEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int MS_NS         = 1000000;
	localparam int MS_CYC        = (MS_NS / CLK_PERIOD_PS) * 1000;

	// Delay unit multiples of one millisecond
	typedef enum logic [1:0] {
		UNIT_1MS   = 2'h0,
		UNIT_10MS  = 2'h1,
		UNIT_100MS = 2'h2,
		UNIT_1S    = 2'h3
	} cmfr_unit_t;

	// Filter path selection codes
	localparam logic [7:0] FILT_VOUT = 8'h00;
	localparam logic [7:0] FILT_IOUT = 8'h01;
	localparam logic [7:0] FILT_FFWD = 8'h02;

endpackage

// [design/cmfr_ocp_if.sv]
// Purpose: Carrier between the register bank and the fast overcurrent filter
// Assumes: All signals on sys_clk
// Notes:   Sample strobe qualifies currentSample
`timescale 1ns/1ps
interface cmfr_ocp_if;
	logic       enable;
	logic [4:0] sampleCount;
	logic [6:0] tripLevel;
	logic       sampleStrobe;
	logic [6:0] currentSample;
	logic       trip;

	modport bank (output enable, output sampleCount, output tripLevel,
		output sampleStrobe, output currentSample, input trip);
	modport filt (input enable, input sampleCount, input tripLevel,
		input sampleStrobe, input currentSample, output trip);
endinterface

// [design/cmfr_ocp_filter.sv]
// Purpose: Fast overcurrent trip after a run of over-level samples
// Assumes: Synchronous reset copy from the bank
// Notes:   A sample count of zero behaves as one
`timescale 1ns/1ps
module cmfr_ocp_filter (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	input  wire logic clkEn,
	// Configuration and samples
	cmfr_ocp_if.filt  ocp
);
	import cmfr_pkg::*;

	logic [4:0] runLen_q;
	logic       trip_q;
	logic       over;

	assign over = ocp.currentSample >= ocp.tripLevel;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			runLen_q <= 5'h00;
		end else if (clkEn) begin
			if (!ocp.enable) begin
				runLen_q <= 5'h00;
			end else if (ocp.sampleStrobe) begin
				// A sample under the level breaks the run
				runLen_q <= over ? ((runLen_q == 5'h1f) ? runLen_q : runLen_q + 5'h01) : 5'h00;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trip_q <= 1'b0;
		end else if (clkEn) begin
			// Run length reached counts the current sample too
			trip_q <= ocp.enable && ocp.sampleStrobe && over &&
				({1'b0, runLen_q} + 6'h01 >= {1'b0, ocp.sampleCount});
		end
	end

	assign ocp.trip = trip_q;
endmodule

// [design/cmfr_delay_timer.sv]
// Purpose: Fault retry or delay timer, count times selected unit
// Assumes: msCycles clock cycles make one millisecond
// Notes:   A start while running restarts; count zero returns to idle with no done pulse
`timescale 1ns/1ps
module cmfr_delay_timer #(
	parameter int unsigned MS_CYCLES = 40000
) (
	// Clock and reset
	input  wire logic            sys_clk,
	input  wire logic            rst_n,
	input  wire logic            clkEn,
	// Control
	input  wire logic            start,
	input  wire logic [7:0]      count,
	input  wire cmfr_pkg::cmfr_unit_t unitSel,
	// Result
	output logic                 done
);
	import cmfr_pkg::*;

	typedef enum logic [1:0] {TM_IDLE = 2'b00, TM_RUN = 2'b01, TM_DONE = 2'b11} cmfr_tstate_t;

	cmfr_tstate_t state_q;
	logic [31:0]  msCnt_q;
	logic [9:0]   unitCnt_q;
	logic [9:0]   unitLen_q;
	logic [7:0]   remain_q;
	logic         msTick;
	logic         unitTick;

	assign msTick   = msCnt_q == MS_CYCLES - 1;
	assign unitTick = msTick && (unitCnt_q == unitLen_q - 10'h001);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q   <= TM_IDLE;
			msCnt_q   <= 32'h0;
			unitCnt_q <= 10'h000;
			unitLen_q <= 10'h001;
			remain_q  <= 8'h00;
		end else if (clkEn) begin
			if (start) begin
				state_q   <= (count == 8'h00) ? TM_DONE : TM_RUN;
				msCnt_q   <= 32'h0;
				unitCnt_q <= 10'h000;
				remain_q  <= count;
				unique case (unitSel)
					UNIT_1MS:   unitLen_q <= 10'd1;
					UNIT_10MS:  unitLen_q <= 10'd10;
					UNIT_100MS: unitLen_q <= 10'd100;
					UNIT_1S:    unitLen_q <= 10'd1000;
				endcase
			end else begin
				unique case (state_q)
					TM_IDLE: state_q <= TM_IDLE;
					TM_RUN: begin
						msCnt_q <= msTick ? 32'h0 : msCnt_q + 32'h1;
						if (msTick) begin
							unitCnt_q <= unitTick ? 10'h000 : unitCnt_q + 10'h001;
						end
						if (unitTick) begin
							remain_q <= remain_q - 8'h01;
							if (remain_q == 8'h01) begin
								state_q <= TM_DONE;
							end
						end
					end
					TM_DONE: state_q <= TM_IDLE;
					default: state_q <= TM_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			done <= 1'b0;
		end else if (clkEn) begin
			done <= !start && state_q == TM_RUN && unitTick && remain_q == 8'h01;
		end
	end
endmodule

// [testbench/cmfr_config_checker.sv]
// Purpose: Port-level checks of the configuration bank
// Assumes: One clock domain; no commands while reset is held
// Notes:   Bound to every bank instance
`timescale 1ns/1ps
module cmfr_config_checker #(
	parameter int unsigned MS_CYCLES = 40000
) (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        arst_n,
	input wire logic        clkEn,
	// Command port
	input wire logic        cmdValid,
	input wire logic        cmdWrite,
	input wire logic [7:0]  cmdCode,
	input wire logic [3:0]  cmdLen,
	input wire logic        rspValid,
	input wire logic [63:0] rspData,
	input wire logic        rspError,
	// Converter side
	input wire logic [15:0] scaleOnCode,
	input wire logic [15:0] scaleOffCode,
	input wire logic        currentStrobe,
	input wire logic        ocpTrip,
	input wire logic [12:0] preTrigCycles,
	input wire logic [2:0]  filterPath
);
	import cmfr_pkg::*;
	logic take;
	assign take = cmdValid && clkEn;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	a_rsp_follows_cmd: assert property (take |=> rspValid)
		else $error("no response after command");
	a_rsp_has_cause: assert property (rspValid |-> $past(take))
		else $error("response without command");
	a_err_zero_data: assert property (rspError |-> rspValid && rspData == 64'h0)
		else $error("refused transfer carries data");
	a_mon_write_refused: assert property (take && cmdWrite && cmdCode == CMD_SCALE_MON |=> rspError)
		else $error("monitor write accepted");
	a_mon_read_data: assert property (take && !cmdWrite && cmdCode == CMD_SCALE_MON && cmdLen == LEN_MON
		|=> !rspError && rspData == {32'h0, $past(scaleOnCode), $past(scaleOffCode)})
		else $error("monitor read data wrong");
	a_ocp_spare_zero: assert property (take && !cmdWrite && cmdCode == CMD_FAST_OCP && cmdLen == LEN_WORD
		|=> !rspError && rspData[63:13] == 51'h0)
		else $error("overcurrent spare bits not zero");
	a_ocp_trip_cause: assert property (ocpTrip |-> $past(currentStrobe) && $past(clkEn))
		else $error("trip without a sample");
	a_pretrig_steps: assert property (preTrigCycles == 13'h0 || (preTrigCycles >= 13'd800
		&& preTrigCycles <= 13'd5390 && (preTrigCycles - 13'd800) % 13'd18 == 13'h0))
		else $error("pretrigger count off grid");
	a_filter_onehot: assert property ($onehot0(filterPath))
		else $error("filter path not one-hot");
endmodule

bind cmfr_config_bank cmfr_config_checker #(.MS_CYCLES(MS_CYCLES)) cmfr_config_checker_inst (
	.sys_clk(sys_clk), .arst_n(arst_n), .clkEn(clkEn), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
	.cmdCode(cmdCode), .cmdLen(cmdLen), .rspValid(rspValid), .rspData(rspData), .rspError(rspError),
	.scaleOnCode(scaleOnCode), .scaleOffCode(scaleOffCode), .currentStrobe(currentStrobe),
	.ocpTrip(ocpTrip), .preTrigCycles(preTrigCycles), .filterPath(filterPath));

// [testbench/cmfr_host_model.sv]
// Purpose: Management host issuing whole transfers on the command port
// Assumes: Tasks are entered at a falling clock edge
// Notes:   Idle data lines show the inverse of their last value
`timescale 1ns/1ps
module cmfr_host_model (
	// Clock
	input wire logic    sys_clk,
	// Command port
	output logic        cmdValid,
	output logic        cmdWrite,
	output logic [7:0]  cmdCode,
	output logic [3:0]  cmdLen,
	output logic [63:0] cmdWrData
);
	import cmfr_pkg::*;
	initial begin
		cmdValid = 1'b0;
		{cmdWrite, cmdCode, cmdLen, cmdWrData} = '0;
	end
	function automatic logic [3:0] lenOf(input logic [7:0] c);
		case (c)
			CMD_FAST_OCP: return LEN_WORD;
			CMD_SCALE_MON: return LEN_MON;
			CMD_SLEW_LIM: return LEN_SLEW;
			default: return LEN_BYTE;
		endcase
	endfunction
	// Any code and length; access uses it for normal transfers, the bench calls it directly where a refusal is wanted
	task automatic raw(input logic w, input logic [7:0] c, input logic [3:0] n, input logic [63:0] d);
		cmdValid = 1'b1;
		cmdWrite = w;
		cmdCode = c;
		cmdLen = n;
		cmdWrData = w ? d : ~cmdWrData;
		@(negedge sys_clk);
	endtask
	task automatic access(input logic w, input logic [7:0] c, input logic [63:0] d);
		raw(w && c != CMD_SCALE_MON, c, lenOf(c), d);
	endtask
	task automatic idle();
		cmdValid = 1'b0;
		cmdWrData = ~cmdWrData;
	endtask
endmodule

// [testbench/tb_top.sv]
// Purpose: Self-checking bench of the configuration bank
// Assumes: One millisecond shortened to ten cycles
// Notes:   Responses are matched in order against a queue of notes
`timescale 1ns/1ps
module tb_top;
	import cmfr_pkg::*;
	localparam int unsigned MS = 10;
	localparam logic [7:0] CODES[8] = '{CMD_RC_THRESH, CMD_KS_PRETRIG, CMD_FAST_OFF, CMD_PG_POL,
		CMD_FAST_OCP, CMD_UNIT_CFG, CMD_SLEW_LIM, CMD_FILTER_SEL};
	localparam logic [17:0] OFF_TAB[4] = '{{8'h20, 8'h2f, 2'b11}, {8'h20, 8'h30, 2'b10},
		{8'h20, 8'h10, 2'b00}, {8'hff, 8'hfe, 2'b11}};
	localparam logic [32:0] PB_TAB[7] = '{{32'h0, 1'b1}, {32'h0064_0032, 1'b1}, {32'h0065_0000, 1'b0},
		{32'hff9b_0000, 1'b0}, {32'h0000_0033, 1'b0}, {32'h0000_ffcd, 1'b0}, {32'hff9c_ffce, 1'b1}};
	localparam logic [7:0] OCP_SEQ[6] = '{{7'h40, 1'b0}, {7'h41, 1'b0}, {7'h3f, 1'b0},
		{7'h7f, 1'b0}, {7'h40, 1'b0}, {7'h40, 1'b1}};
	logic        sys_clk, arst_n, clkEn, cmdValid, cmdWrite, rspValid, rspError, vinFallingFast;
	logic        powerGoodRaw, currentStrobe, kickArm, remoteTrigger, fastInputOff, powerOkOutput;
	logic        ocpTrip, kickStart, prebiasStartOk;
	logic [7:0]  cmdCode, remoteSenseInput, vinLevel, inputOffThreshold;
	logic [3:0]  cmdLen, faultStart, faultDelayDone;
	logic [63:0] cmdWrData, rspData;
	logic [6:0]  currentSample;
	logic [31:0] faultCount;
	logic [31:0] seed = 32'he7c1;
	logic [15:0] scaleOnCode, scaleOffCode, vinSlew, voutSlew;
	logic [12:0] preTrigCycles;
	logic [2:0]  filterPath;
	logic [64:0] expQ[$];
	int          mismatches, n_compared;

	cmfr_config_bank #(.MS_CYCLES(MS)) cmfr_config_bank_inst (.sys_clk, .arst_n, .clkEn, .cmdValid,
		.cmdWrite, .cmdCode, .cmdLen, .cmdWrData, .rspValid, .rspData, .rspError, .remoteSenseInput,
		.vinLevel, .vinFallingFast, .powerGoodRaw, .inputOffThreshold, .currentSample, .currentStrobe,
		.kickArm, .faultStart, .faultCount, .scaleOnCode, .scaleOffCode, .vinSlew, .voutSlew,
		.remoteTrigger, .fastInputOff, .powerOkOutput, .ocpTrip, .kickStart, .preTrigCycles,
		.faultDelayDone, .prebiasStartOk, .filterPath);
	cmfr_host_model cmfr_host_model_inst (.sys_clk, .cmdValid, .cmdWrite, .cmdCode, .cmdLen, .cmdWrData);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input logic [64:0] got, input logic [64:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] c, input logic [63:0] d);
		expQ.push_back(65'h0);
		cmfr_host_model_inst.access(1'b1, c, d);
	endtask
	task automatic rd(input logic [7:0] c, input logic [63:0] e);
		expQ.push_back({1'b0, e});
		cmfr_host_model_inst.access(1'b0, c, 64'h0);
	endtask
	task automatic bad(input logic w, input logic [7:0] c, input logic [3:0] n);
		expQ.push_back({1'b1, 64'h0});
		cmfr_host_model_inst.raw(w, c, n, {rnd(), rnd()});
	endtask
	// Pins need three edges to reach the outputs
	task automatic settle();
		cmfr_host_model_inst.idle();
		repeat (4) @(negedge sys_clk);
	endtask
	task automatic ocpStep(input logic [6:0] s, input logic e);
		currentSample = s;
		currentStrobe = 1'b1;
		@(negedge sys_clk);
		// The trip pulse stands only in the cycle after the strobe edge
		chk(ocpTrip, e);
		currentStrobe = 1'b0;
		currentSample = ~s;
		@(negedge sys_clk);
	endtask

	// A response with no note left is compared against unknown and fails
	always @(negedge sys_clk) begin
		if (rspValid === 1'b1) begin
			chk({rspError, rspData}, expQ.size() > 0 ? expQ.pop_front() : 65'bx);
		end
	end

	initial begin
		logic [63:0] v, m, k;
		logic        e1;
		logic [4:0]  ev;
		int          t[5];
		arst_n = 1'b0;
		clkEn = 1'b1;
		{remoteSenseInput, vinLevel, inputOffThreshold, vinFallingFast, powerGoodRaw, currentSample} = '0;
		{currentStrobe, kickArm, faultStart, faultCount, scaleOnCode, scaleOffCode, vinSlew, voutSlew} = '0;
		repeat (8) @(negedge sys_clk);
		arst_n = 1'b1;
		repeat (3) @(negedge sys_clk);
		foreach (CODES[i]) begin
			m = CODES[i] == CMD_SLEW_LIM ? '1 : CODES[i] == CMD_FAST_OCP ? 64'hffff : 64'hff;
			v = {rnd(), rnd()} & m;
			rd(CODES[i], 64'h0);
			wr(CODES[i], v);
			rd(CODES[i], CODES[i] == CMD_FAST_OCP ? v & 64'h1fff : v);
		end
		$display("registers done");
		scaleOnCode = 16'(rnd());
		scaleOffCode = 16'(rnd());
		bad(1'b1, CMD_SCALE_MON, LEN_MON);
		bad(1'b0, CMD_SLEW_LIM, LEN_MON);
		bad(1'b0, CMD_FAST_OCP, LEN_BYTE);
		bad(1'b0, 8'hcf, LEN_BYTE);
		rd(CMD_SCALE_MON, {32'h0, scaleOnCode, scaleOffCode});
		$display("refusals done");
		for (int p = 0; p < 2; p++) begin
			wr(CMD_PG_POL, 64'(p));
			for (int g = 0; g < 2; g++) begin
				powerGoodRaw = g[0];
				settle();
				chk(powerOkOutput, p ? g : !g);
			end
		end
		wr(CMD_RC_THRESH, 64'h80);
		bad(1'b1, CMD_RC_THRESH, LEN_WORD);
		for (int s = 127; s < 129; s++) begin
			remoteSenseInput = 8'(s);
			settle();
			chk(remoteTrigger, s >= 128);
		end
		wr(CMD_FAST_OFF, 64'h10);
		foreach (OFF_TAB[i]) begin
			{inputOffThreshold, vinLevel, vinFallingFast, e1} = OFF_TAB[i];
			settle();
			chk(fastInputOff, e1);
		end
		for (int f = 0; f < 4; f++) begin
			wr(CMD_FILTER_SEL, 64'(f));
			settle();
			chk(filterPath, f < 3 ? 3'b001 << f : 3'b000);
		end
		wr(CMD_SLEW_LIM, 64'h0064_ff9c_0032_ffce);
		foreach (PB_TAB[i]) begin
			{vinSlew, voutSlew, e1} = PB_TAB[i];
			settle();
			chk(prebiasStartOk, e1);
		end
		// A frozen bank must not pass the pin change on
		clkEn = 1'b0;
		powerGoodRaw = 1'b0;
		settle();
		chk(powerOkOutput, 1'b1);
		clkEn = 1'b1;
		settle();
		chk(powerOkOutput, 1'b0);
		$display("pins done");
		wr(CMD_FAST_OCP, 64'he3c0);
		settle();
		foreach (OCP_SEQ[i]) ocpStep(OCP_SEQ[i][7:1], OCP_SEQ[i][0]);
		wr(CMD_FAST_OCP, 64'h037f);
		settle();
		repeat (4) ocpStep(7'h7f, 1'b0);
		// A run left over from before the disable would trip at once here
		wr(CMD_FAST_OCP, 64'h0280);
		settle();
		ocpStep(7'h00, 1'b0);
		wr(CMD_FAST_OCP, 64'h0080);
		settle();
		ocpStep(7'h00, 1'b1);
		$display("overcurrent done");
		k = {56'h0, 8'(rnd())};
		wr(CMD_UNIT_CFG, 64'he4);
		wr(CMD_KS_PRETRIG, k);
		settle();
		chk(preTrigCycles, 800 + 18 * k);
		faultCount = 32'h0102_0507;
		kickArm = 1'b1;
		faultStart = 4'hf;
		t = '{default: 0};
		for (int n = 1; n <= 10100; n++) begin
			@(negedge sys_clk);
			kickArm = 1'b0;
			faultStart = 4'h0;
			ev = {kickStart, faultDelayDone};
			for (int b = 0; b < 5; b++) begin
				if (ev[b] === 1'b1 && t[b] == 0) t[b] = n;
			end
		end
		foreach (t[b]) begin
			if (t[b] == 0) begin
				mismatches++;
				stop_test();
			end
		end
		chk(t[0], 7 * 1 * MS + 1);
		chk(t[1], 5 * 10 * MS + 1);
		chk(t[2], 2 * 100 * MS + 1);
		chk(t[3], 1 * 1000 * MS + 1);
		chk(t[4], 800 + 18 * k + 1);
		$display("timers done");
		repeat (4) @(negedge sys_clk);
		chk(expQ.size(), 0);
		stop_test();
	end
endmodule
